/* hdl/otp_temp_range_select.sv */
// Bank choice, temperature range search, command gating and busy output
// ****************************************************************
// ****************************************************************
`include "otp_temp_range_select_consts.svh"

module otp_temp_range_select #(
	parameter int REFRESH_CYCLES = 64,
	parameter int ACTION_CYCLES = 16,
	parameter int OTP_DEPTH = `OTP_SIZE
) (
	input wire logic clk,
	input wire logic rst,
	input wire otp_temp_range_select_pkg::cmd_t cmdIn,
	input wire logic [7:0] temperature,
	input wire otp_temp_range_select_pkg::otp_req_t progReq,
	output logic busyN,
	output logic cmdAccepted,
	output logic refreshAbort,
	output logic selValid,
	output otp_temp_range_select_pkg::sel_result_t selResult,
	output logic [7:0] progRdData
);
	import otp_temp_range_select_pkg::*;

	// ****************************************************************
	// Waveform memory
	// ****************************************************************
	// Array starts erased; a write can only clear bits
	logic [7:0] otpMem [0:OTP_DEPTH-1];
	logic [7:0] selRd_reg;
	logic [7:0] progRdData_reg;
	otp_addr_t rdAddr;
	wire progInRange = progReq.addr <= `OTP_LAST_ADDR;

	// Blank content is all ones
	initial begin
		for (int i = 0; i < OTP_DEPTH; i++) begin
			otpMem[i] = `OTP_BLANK_BYTE;
		end
	end

	// Program by AND and keep two read ports
	always_ff @(posedge clk) begin
		if (progReq.wr && progInRange) begin
			otpMem[progReq.addr] <= otpMem[progReq.addr] & progReq.wdata;
		end
		selRd_reg <= otpMem[rdAddr];
		progRdData_reg <= progInRange ? otpMem[progReq.addr] : `OTP_BLANK_BYTE;
	end

	// ****************************************************************
	// Command decode
	// ****************************************************************
	sel_state_t state_reg, state_next;
	logic busyN_reg, cmdAccepted_reg, refreshAbort_reg, selValid_reg;
	logic bank_reg, defOn_reg;
	logic [3:0] tbIdx_reg;
	logic [3:0] range_reg;
	logic [7:0] temp_reg;
	logic [15:0] cnt_reg;
	logic rdPend_reg;

	wire [7:0] code = cmdIn.code;
	wire refreshing = state_reg != ST_IDLE && state_reg != ST_BUSY;
	wire isReadCmd = code == `CMD_REVISION_READ || code == `CMD_STATUS_FLAG_READ
		|| code == `CMD_VCOM_VALUE_READ || code == `CMD_OTP_READ;
	wire flagCmd = code == `CMD_POWER_OFF || code == `CMD_POWER_ON
		|| code == `CMD_POWER_MEASURE || code == `CMD_DEEP_SLEEP
		|| code == `CMD_AUTO_SEQ || code == `CMD_DATA_STOP
		|| code == `CMD_DISPLAY_REFRESH || code == `CMD_SENSOR_CAL
		|| code == `CMD_LOW_SUPPLY || code == `CMD_AUTO_VCOM
		|| code == `CMD_OTP_PROG_ACT;
	// Refresh lets only reads through
	wire accept = cmdIn.valid && (!refreshing || isReadCmd);
	wire startRefresh = accept && state_reg == ST_IDLE && code == `CMD_DISPLAY_REFRESH;
	wire startAction = accept && state_reg == ST_IDLE && flagCmd && !startRefresh;

	// ****************************************************************
	// Address and comparison
	// ****************************************************************
	wire [12:0] bankBase = bank_reg ? `OTP_BANK1_BASE : `OTP_BANK0_BASE;
	wire [12:0] tbAddr = bankBase + `OTP_TB_FIRST_OFS + {9'h000, tbIdx_reg};
	wire [12:0] keyAddr = bankBase + `OTP_DEF_FIRST_OFS;
	// Signed comparison so 0x7F stops every search
	wire tempLeBound = $signed(temp_reg) <= $signed(selRd_reg);
	wire lastTb = tbIdx_reg == `TB_COUNT - 4'h1;
	wire [12:0] rangeMul = 13'(`OTP_RANGE_SIZE * range_reg);
	wire [12:0] rangeBase = bankBase + `OTP_RANGE_BASE_OFS + rangeMul;
	wire actDone = cnt_reg == 16'h0000;

	// Events of the read walk and the refresh phase
	wire bank1Seen = state_reg == ST_RD_CHECK1 && rdPend_reg;
	wire keySeen = state_reg == ST_RD_KEY && rdPend_reg;
	wire tbSeen = state_reg == ST_RD_TB && rdPend_reg;
	wire refreshEnter = state_next == ST_REFRESH && state_reg != ST_REFRESH;
	wire abortNow = state_reg == ST_RD_CHECK1 && state_next == ST_IDLE;
	wire selFirst = state_reg == ST_REFRESH && state_next == ST_REFRESH
		&& cnt_reg == 16'(REFRESH_CYCLES - 1);

	// Memory address for the current step
	always_comb begin
		rdAddr = `OTP_BANK0_BASE + `OTP_CHECK_OFS;
		case (state_reg)
			ST_RD_CHECK1: rdAddr = `OTP_BANK1_BASE + `OTP_CHECK_OFS;
			ST_RD_KEY: rdAddr = keyAddr;
			ST_RD_TB: rdAddr = tbAddr;
			default: rdAddr = `OTP_BANK0_BASE + `OTP_CHECK_OFS;
		endcase
	end

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	// Next state; reads take one cycle, rdPend marks data ready
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (startRefresh) begin
					state_next = ST_RD_CHECK0;
				end else if (startAction) begin
					state_next = ST_BUSY;
				end
			end
			ST_RD_CHECK0: begin
				if (rdPend_reg) begin
					state_next = selRd_reg == `OTP_CHECK_KEY ? ST_RD_KEY : ST_RD_CHECK1;
				end
			end
			ST_RD_CHECK1: begin
				if (rdPend_reg) begin
					state_next = selRd_reg == `OTP_CHECK_KEY ? ST_RD_KEY : ST_IDLE;
				end
			end
			ST_RD_KEY: begin
				if (rdPend_reg) begin
					state_next = ST_RD_TB;
				end
			end
			ST_RD_TB: begin
				if (rdPend_reg && (tempLeBound || lastTb)) begin
					state_next = ST_REFRESH;
				end
			end
			ST_REFRESH: begin
				if (actDone) begin
					state_next = ST_IDLE;
				end
			end
			ST_BUSY: begin
				if (actDone) begin
					state_next = ST_IDLE;
				end
			end
			default: state_next = ST_IDLE;
		endcase
	end

	// State register and read pacing
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= ST_IDLE;
			rdPend_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			rdPend_reg <= state_next == state_reg && !rdPend_reg;
		end
	end

	// Temperature is frozen when the refresh starts
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			temp_reg <= 8'h00;
		end else if (startRefresh) begin
			temp_reg <= temperature;
		end
	end

	// Bank flag: cleared on start, set once the upper check is read
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bank_reg <= 1'b0;
		end else if (startRefresh) begin
			bank_reg <= 1'b0;
		end else if (bank1Seen) begin
			bank_reg <= 1'b1;
		end
	end

	// Defaults key taken from the chosen bank
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			defOn_reg <= 1'b0;
		end else if (keySeen) begin
			defOn_reg <= selRd_reg == `OTP_DEF_KEY;
		end
	end

	// Boundary walk: range follows the boundary index
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tbIdx_reg <= 4'h0;
			range_reg <= 4'h0;
		end else if (state_reg == ST_RD_KEY) begin
			tbIdx_reg <= 4'h0;
			range_reg <= 4'h0;
		end else if (tbSeen) begin
			if (tempLeBound) begin
				range_reg <= tbIdx_reg;
			end else if (lastTb) begin
				range_reg <= `TB_COUNT;
			end else begin
				tbIdx_reg <= tbIdx_reg + 4'h1;
			end
		end
	end

	// Busy duration counter
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_reg <= 16'h0000;
		end else if (startAction) begin
			cnt_reg <= 16'(ACTION_CYCLES - 1);
		end else if (refreshEnter) begin
			cnt_reg <= 16'(REFRESH_CYCLES - 1);
		end else if (!actDone) begin
			cnt_reg <= cnt_reg - 16'h0001;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	// Busy pin follows the next state so it drops with the accepting edge
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			busyN_reg <= 1'b1;
		end else begin
			busyN_reg <= state_next == ST_IDLE;
		end
	end

	// One-cycle acceptance pulse
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cmdAccepted_reg <= 1'b0;
		end else begin
			cmdAccepted_reg <= accept;
		end
	end

	// One-cycle abort pulse when neither bank is valid
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			refreshAbort_reg <= 1'b0;
		end else begin
			refreshAbort_reg <= abortNow;
		end
	end

	// Strobe in the second refresh cycle only
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			selValid_reg <= 1'b0;
		end else begin
			selValid_reg <= selFirst;
		end
	end

	// Result loads with the strobe and then holds
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			selResult <= '0;
		end else if (selFirst) begin
			selResult <= '{bank: bank_reg, range: range_reg, rangeBase: rangeBase,
				defaultsOn: defOn_reg};
		end
	end

	assign busyN = busyN_reg;
	assign cmdAccepted = cmdAccepted_reg;
	assign refreshAbort = refreshAbort_reg;
	assign selValid = selValid_reg;
	assign progRdData = progRdData_reg;
endmodule

/* hdl/otp_temp_range_select_consts.svh */
// Constants for the waveform memory bank and temperature range selector
`ifndef OTP_TEMP_RANGE_SELECT_CONSTS_SVH
`define OTP_TEMP_RANGE_SELECT_CONSTS_SVH

// ****************************************************************
// Memory map
// ****************************************************************
`define OTP_SIZE 6144
`define OTP_LAST_ADDR 13'h17FF
`define OTP_BANK_SIZE 13'hC00
`define OTP_BANK0_BASE 13'h000
`define OTP_BANK1_BASE 13'hC00
`define OTP_CHECK_OFS 13'h000
`define OTP_TB_FIRST_OFS 13'h001
`define OTP_TB_LAST_OFS 13'h00B
`define OTP_DEF_FIRST_OFS 13'h00C
`define OTP_DEF_LAST_OFS 13'h01E
`define OTP_BORDER_FIRST_OFS 13'h01F
`define OTP_BORDER_LAST_OFS 13'h048
`define OTP_RANGE_BASE_OFS 13'h049
`define OTP_RANGE_SIZE 13'h0F7
`define OTP_RSVD_FIRST 13'hBF0
`define OTP_RSVD_LAST 13'hBFF
`define OTP_CHECK_KEY 8'hA5
`define OTP_DEF_KEY 8'hA5
`define OTP_BLANK_BYTE 8'hFF
`define OTP_END_BOUNDARY 8'h7F
`define TB_COUNT 4'hB

// ****************************************************************
// Command codes
// ****************************************************************
`define CMD_POWER_OFF 8'h02
`define CMD_POWER_ON 8'h04
`define CMD_POWER_MEASURE 8'h05
`define CMD_DEEP_SLEEP 8'h07
`define CMD_AUTO_SEQ 8'h17
`define CMD_DATA_STOP 8'h11
`define CMD_DISPLAY_REFRESH 8'h12
`define CMD_SENSOR_CAL 8'h40
`define CMD_LOW_SUPPLY 8'h51
`define CMD_REVISION_READ 8'h70
`define CMD_STATUS_FLAG_READ 8'h71
`define CMD_AUTO_VCOM 8'h80
`define CMD_VCOM_VALUE_READ 8'h81
`define CMD_OTP_PROG_ACT 8'hA1
`define CMD_OTP_READ 8'hA2

`endif

/* hdl/otp_temp_range_select_pkg.sv */
// Types for the waveform memory bank and temperature range selector
package otp_temp_range_select_pkg;
	typedef logic [12:0] otp_addr_t;
	typedef logic [7:0] otp_byte_t;

	// Command strobe with its code
	typedef struct packed {
		logic valid;
		logic [7:0] code;
	} cmd_t;

	// Memory program and read port request
	typedef struct packed {
		logic rd;
		logic wr;
		otp_addr_t addr;
		otp_byte_t wdata;
	} otp_req_t;

	// Result of one range selection
	typedef struct packed {
		logic bank;
		logic [3:0] range;
		otp_addr_t rangeBase;
		logic defaultsOn;
	} sel_result_t;

	typedef enum {
		ST_IDLE, ST_RD_CHECK0, ST_RD_CHECK1, ST_RD_KEY, ST_RD_TB, ST_REFRESH, ST_BUSY
	} sel_state_t;
endpackage

/* test/otp_temp_range_select_properties.sv */
// Checker of busy, command gating and range selection at the selector ports
`include "otp_temp_range_select_consts.svh"
module otp_temp_range_select_properties (
	input wire logic clk,
	input wire logic rst,
	input wire otp_temp_range_select_pkg::cmd_t cmdIn,
	input wire logic [7:0] temperature,
	input wire otp_temp_range_select_pkg::otp_req_t progReq,
	input wire logic busyN,
	input wire logic cmdAccepted,
	input wire logic refreshAbort,
	input wire logic selValid,
	input wire otp_temp_range_select_pkg::sel_result_t selResult,
	input wire logic [7:0] progRdData
);
	timeunit 1ns;
	timeprecision 1ns;
	import otp_temp_range_select_pkg::*;
	logic refresh_reg;
	logic isRead;
	logic isFlag;
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	// Command classes
	assign isRead = cmdIn.valid && cmdIn.code inside {`CMD_REVISION_READ, `CMD_STATUS_FLAG_READ,
		`CMD_VCOM_VALUE_READ, `CMD_OTP_READ};
	assign isFlag = cmdIn.valid && cmdIn.code inside {`CMD_POWER_OFF, `CMD_POWER_ON,
		`CMD_POWER_MEASURE, `CMD_DEEP_SLEEP, `CMD_AUTO_SEQ, `CMD_DATA_STOP, `CMD_DISPLAY_REFRESH,
		`CMD_SENSOR_CAL, `CMD_LOW_SUPPLY, `CMD_AUTO_VCOM, `CMD_OTP_PROG_ACT};
	// Marks a running refresh until busy returns high
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			refresh_reg <= 1'b0;
		else if (isFlag && cmdIn.code == `CMD_DISPLAY_REFRESH && busyN)
			refresh_reg <= 1'b1;
		else if (busyN)
			refresh_reg <= 1'b0;
	end
	refresh_gate_a: assert property (refresh_reg && !busyN && cmdIn.valid && !isRead |=> !cmdAccepted)
		else $error("command accepted during refresh");
	read_pass_a: assert property (refresh_reg && isRead |=> cmdAccepted)
		else $error("read refused during refresh");
	flag_busy_a: assert property (busyN && isFlag |=> !busyN && cmdAccepted)
		else $error("flagged command left busy high");
	busy_hold_a: assert property (busyN && !isFlag |=> busyN)
		else $error("busy fell without flagged command");
	busy_end_a: assert property ($fell(busyN) |-> ##[1:200] busyN)
		else $error("busy never returned high");
	sel_refresh_a: assert property (selValid |-> refresh_reg && !busyN && !refreshAbort)
		else $error("selection outside refresh");
	range_max_a: assert property (selValid |-> selResult.range <= 4'hB)
		else $error("range above eleven");
	range_base_a: assert property (selValid |-> selResult.rangeBase == (selResult.bank ?
		13'hC00 : 13'h000) + 13'h049 + 13'h0F7 * 13'(selResult.range))
		else $error("range base wrong");
	sel_hold_a: assert property (!$stable(selResult) |-> selValid)
		else $error("selection changed without strobe");
	abort_idle_a: assert property (refreshAbort |-> ##[0:1] busyN)
		else $error("busy held after abort");
endmodule
bind otp_temp_range_select otp_temp_range_select_properties chk (.clk(clk), .rst(rst),
	.cmdIn(cmdIn), .temperature(temperature), .progReq(progReq), .busyN(busyN),
	.cmdAccepted(cmdAccepted), .refreshAbort(refreshAbort), .selValid(selValid),
	.selResult(selResult), .progRdData(progRdData));

/* test/host_cmd_model.sv */
// Host model issuing commands and programming the waveform memory
module host_cmd_model (
	input wire logic clk,
	output otp_temp_range_select_pkg::cmd_t cmdOut,
	output otp_temp_range_select_pkg::otp_req_t progOut
);
	timeunit 1ns;
	timeprecision 1ns;
	import otp_temp_range_select_pkg::*;
	initial begin
		cmdOut = '0;
		progOut = '0;
	end
	// ****************************************
	// Requests change at falling edges
	// ****************************************
	task automatic send(input logic [7:0] code);
		@(negedge clk);
		cmdOut = {1'b1, code};
		@(negedge clk);
		cmdOut = {1'b0, ~code}; // Released code must not look meaningful
	endtask
	task automatic prog(input otp_addr_t a, input otp_byte_t d);
		@(negedge clk);
		progOut = {1'b0, 1'b1, a, d};
		@(negedge clk);
		progOut = {1'b0, 1'b0, a, ~d};
	endtask
	task automatic peek(input otp_addr_t a);
		@(negedge clk);
		progOut = {1'b1, 1'b0, a, 8'h00};
		@(negedge clk);
	endtask
endmodule

/* test/tb_otp_temp_range_select.sv */
// Self-checking bench for the range selector
`include "otp_temp_range_select_consts.svh"
module tb_otp_temp_range_select;
	timeunit 1ns;
	timeprecision 1ns;
	import otp_temp_range_select_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] temperature = 8'h00;
	cmd_t cmdIn;
	otp_req_t progReq;
	logic busyN, cmdAccepted, refreshAbort, selValid;
	sel_result_t selResult;
	logic [7:0] progRdData;
	int mismatches = 0;
	int checksDone = 0;
	localparam int watchSel = 0;
	localparam int watchBusy = 1;
	localparam int watchAbort = 2;
	logic [7:0] rndCode;
	logic [31:0] seed = 32'h24;
	logic [7:0] bnd [2][11] = '{'{8'hF1, 8'hFB, 8'h00, 8'h0A, 8'h1E, 8'h7F, 8'hFF, 8'hFF,
		8'hFF, 8'hFF, 8'hFF}, '{8'hD8, 8'hE2, 8'hEC, 8'hF6, 8'h00, 8'h05, 8'h0A, 8'h0F,
		8'h14, 8'h1E, 8'h28}};
	logic [7:0] flagged [11] = '{`CMD_POWER_OFF, `CMD_POWER_ON, `CMD_POWER_MEASURE,
		`CMD_DEEP_SLEEP, `CMD_AUTO_SEQ, `CMD_DATA_STOP, `CMD_DISPLAY_REFRESH, `CMD_SENSOR_CAL,
		`CMD_LOW_SUPPLY, `CMD_AUTO_VCOM, `CMD_OTP_PROG_ACT};
	always #50 clk = ~clk;
	host_cmd_model host (.clk(clk), .cmdOut(cmdIn), .progOut(progReq));
	otp_temp_range_select #(.REFRESH_CYCLES(4), .ACTION_CYCLES(2)) DUT (.clk(clk), .rst(rst),
		.cmdIn(cmdIn), .temperature(temperature), .progReq(progReq), .busyN(busyN),
		.cmdAccepted(cmdAccepted), .refreshAbort(refreshAbort), .selValid(selValid),
		.selResult(selResult), .progRdData(progRdData));
	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [31:0] xorshift();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Whether a command code is one that pulls busy low
	function automatic logic flag_code(input logic [7:0] c);
		logic hit;
		hit = 1'b0;
		for (int k = 0; k < 11; k++)
			if (flagged[k] == c) hit = 1'b1;
		return hit;
	endfunction
	function automatic sel_result_t exp_sel(input logic [7:0] t, input logic b);
		sel_result_t r;
		r.range = 4'hB;
		for (int i = 10; i >= 0; i--)
			if ($signed(t) <= $signed(bnd[b][i])) r.range = 4'(i);
		r.bank = b;
		r.rangeBase = (b ? 13'hC00 : 13'h000) + 13'h049 + 13'h0F7 * 13'(r.range);
		r.defaultsOn = b; // Only the upper bank holds the key
		return r;
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checksDone++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checksDone, mismatches);
		if (mismatches == 0 && checksDone > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Live value of a watched output
	function automatic logic watched(input int which);
		case (which)
			watchSel: return selValid;
			watchBusy: return busyN;
			default: return refreshAbort;
		endcase
	endfunction
	task automatic wait_sig(input int which, input logic v);
		int n;
		for (n = 0; n < 200 && watched(which) !== v; n++)
			@(negedge clk);
		if (n == 200) begin
			mismatches++;
			complete_run();
		end
	endtask
	task automatic refresh(input logic [7:0] t, input logic b, input logic g);
		@(negedge clk);
		temperature = t;
		host.send(`CMD_DISPLAY_REFRESH);
		check({cmdAccepted, busyN}, 2'b10);
		if (g) begin
			host.send(`CMD_POWER_MEASURE);
			check(cmdAccepted, 1'b0);
			host.send(`CMD_STATUS_FLAG_READ);
			check(cmdAccepted, 1'b1);
		end
		wait_sig(watchSel, 1'b1);
		check(selResult, exp_sel(t, b));
		wait_sig(watchBusy, 1'b1);
	endtask
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (5) @(negedge clk);
		rst = 1'b0;
		host.peek(13'h17FF);
		check(progRdData, 8'hFF);
		host.prog(13'h17FF, 8'h3C);
		host.prog(13'h17FF, 8'hF0);
		host.peek(13'h17FF);
		check(progRdData, 8'h30);
		host.prog(13'h1800, 8'h00);
		host.peek(13'h0000);
		check(progRdData, 8'hFF);
		for (int a = 'hBF0; a <= 'hBFF; a++)
			host.prog(13'(a), 8'hFF);
		host.send(`CMD_DISPLAY_REFRESH);
		wait_sig(watchAbort, 1'b1);
		check(selValid, 1'b0);
		wait_sig(watchBusy, 1'b1);
		$display("memory and abort done");
		for (int i = 0; i < 11; i++) begin
			host.prog(13'hC01 + 13'(i), bnd[1][i]);
			host.prog(13'h001 + 13'(i), bnd[0][i]);
		end
		host.prog(13'hC0C, 8'hA5);
		host.prog(13'hC00, 8'hA5);
		refresh(8'h80, 1'b1, 1'b1);
		refresh(bnd[1][0], 1'b1, 1'b0);
		refresh(8'h29, 1'b1, 1'b0);
		repeat (10) refresh(8'(xorshift()), 1'b1, 1'b0);
		host.prog(13'h000, 8'hA5);
		refresh(8'h7F, 1'b0, 1'b0);
		repeat (10) refresh(8'(xorshift()), 1'b0, 1'b0);
		$display("range search done");
		for (int i = 0; i < 11; i++) begin
			host.send(flagged[i]);
			check(busyN, 1'b0);
			wait_sig(watchBusy, 1'b1);
			host.send(`CMD_OTP_READ);
			check({cmdAccepted, busyN}, 2'b11);
		end
		for (int i = 0; i < 20; i++) begin
			rndCode = 8'(xorshift());
			host.send(rndCode);
			check({cmdAccepted, busyN}, {1'b1, !flag_code(rndCode)});
			wait_sig(watchBusy, 1'b1);
		end
		$display("busy flags done");
		complete_run();
	end
endmodule
